// ==== rtl/dotc_pkg.sv ====
// Constants and types shared by the termination timing control block
package dotc_pkg;
  localparam int unsigned LAT_W     = 6;
  localparam int unsigned DLY_DEPTH = 64;
  localparam int unsigned EV_W      = 2;
  localparam int unsigned CNT_W     = 4;
  localparam int unsigned RTT_W     = 3;
  localparam int unsigned MODE_W    = 14;
  localparam int unsigned CFG_W     = 3;
  localparam int unsigned PIN_W     = 6;

  localparam logic [LAT_W-1:0] LAT_MAX  = 6'h3f;
  localparam logic [7:0]       SUB_PRE1 = 8'h02;
  localparam logic [7:0]       SUB_PRE2 = 8'h03;

  // Read disable window length, per burst and preamble
  localparam logic [CNT_W-1:0] RD_BC4_PRE1 = 4'h4;
  localparam logic [CNT_W-1:0] RD_BC4_PRE2 = 4'h5;
  localparam logic [CNT_W-1:0] RD_BL8_PRE1 = 4'h6;
  localparam logic [CNT_W-1:0] RD_BL8_PRE2 = 4'h7;
  // Write termination window length, per burst, preamble and CRC
  localparam logic [CNT_W-1:0] WR_BC4_P1_C0 = 4'h4;
  localparam logic [CNT_W-1:0] WR_BC4_P1_C1 = 4'h7;
  localparam logic [CNT_W-1:0] WR_BC4_P2_C0 = 4'h5;
  localparam logic [CNT_W-1:0] WR_BC4_P2_C1 = 4'h8;
  localparam logic [CNT_W-1:0] WR_BL8_P1_C0 = 4'h6;
  localparam logic [CNT_W-1:0] WR_BL8_P1_C1 = 4'h7;
  localparam logic [CNT_W-1:0] WR_BL8_P2_C0 = 4'h7;
  localparam logic [CNT_W-1:0] WR_BL8_P2_C1 = 4'h8;
  // Minimum assertion time of the pin
  localparam logic [CNT_W-1:0] HOLD_BC4_PRE1 = 4'h4;
  localparam logic [CNT_W-1:0] HOLD_BC4_PRE2 = 4'h5;
  localparam logic [CNT_W-1:0] HOLD_BL8_PRE1 = 4'h6;
  localparam logic [CNT_W-1:0] HOLD_BL8_PRE2 = 4'h7;
  localparam logic [CNT_W-1:0] HOLD_CRC_EXT  = 4'h1;

  localparam logic [11:0] ADDR_MODE1 = 12'h000;
  localparam logic [11:0] ADDR_MODE2 = 12'h004;
  localparam logic [11:0] ADDR_MODE5 = 12'h008;
  localparam logic [11:0] ADDR_LAT   = 12'h00c;
  localparam logic [11:0] ADDR_CFG   = 12'h010;
  localparam logic [11:0] ADDR_STAT  = 12'h014;

  localparam int unsigned MR1_NOM_LSB  = 8;
  localparam int unsigned MR2_WR_LSB   = 9;
  localparam int unsigned MR5_PARK_LSB = 6;
  localparam int unsigned LAT_CWL_LSB  = 0;
  localparam int unsigned LAT_AL_LSB   = 8;
  localparam int unsigned LAT_PL_LSB   = 16;
  localparam int unsigned LAT_CL_LSB   = 24;
  localparam int unsigned CFG_PRE2_BIT = 0;
  localparam int unsigned CFG_CRC_BIT  = 1;
  localparam int unsigned CFG_CHOP_BIT = 2;
  localparam int unsigned STAT_TERM_LSB = 0;
  localparam int unsigned STAT_LOCK_BIT = 8;
  localparam int unsigned STAT_HERR_BIT = 9;
  localparam int unsigned STAT_CODE_LSB = 16;

  localparam int unsigned PIN_CK   = 0;
  localparam int unsigned PIN_ODT  = 1;
  localparam int unsigned PIN_WR   = 2;
  localparam int unsigned PIN_RD   = 3;
  localparam int unsigned PIN_CHOP = 4;
  localparam int unsigned PIN_LOCK = 5;

  localparam logic [MODE_W-1:0] MODE_RST = 14'h0000;
  localparam logic [31:0]       LAT_RST  = 32'h0000_0000;
  localparam logic [CFG_W-1:0]  CFG_RST  = 3'h0;

  typedef enum logic [4:0] {
    TERM_HIZ  = 5'h01,
    TERM_PARK = 5'h02,
    TERM_NOM  = 5'h04,
    TERM_WR   = 5'h08,
    TERM_DIS  = 5'h10
  } dotc_term_t;
endpackage

// ==== rtl/dotc_tap_if.sv ====
// Carrier between the control logic and one latency shift line
interface dotc_tap_if;
  logic                         step;
  logic                         clear;
  logic [dotc_pkg::EV_W-1:0]    din;
  logic [dotc_pkg::LAT_W-1:0]   lat;
  logic [dotc_pkg::EV_W-1:0]    tap;
  modport src  (output step, output clear, output din, output lat, input tap);
  modport line (input step, input clear, input din, input lat, output tap);
endinterface

// ==== rtl/dotc_delay_line.sv ====
// Per-clock shift line with a programmable latency tap
module dotc_delay_line (
  input  wire logic clk_sys_i,
  input  wire logic rst_b_i,
  input  wire logic ce_i,
  dotc_tap_if.line  tap_if
);
  logic [dotc_pkg::EV_W-1:0] sr_q [dotc_pkg::DLY_DEPTH];
  wire  logic                lat_zero;
  wire  logic [dotc_pkg::LAT_W-1:0] tap_idx;

  assign lat_zero   = (tap_if.lat == '0);
  assign tap_idx    = tap_if.lat - 6'h01;
  assign tap_if.tap = lat_zero ? tap_if.din : sr_q[tap_idx];

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < dotc_pkg::DLY_DEPTH; i++) sr_q[i] <= '0;
    end else if (ce_i && tap_if.clear) begin
      for (int i = 0; i < dotc_pkg::DLY_DEPTH; i++) sr_q[i] <= '0;
    end else if (ce_i && tap_if.step) begin
      sr_q[0] <= tap_if.din;
      for (int i = 1; i < dotc_pkg::DLY_DEPTH; i++) sr_q[i] <= sr_q[i-1];
    end
  end
endmodule

// ==== rtl/dotc_odt_ctrl.sv ====
// Synchronous and dynamic on-die termination timing control with APB registers
// How it works
// - Synchronous timing whenever DLL is locked
// - Nominal on/off direct latency after pin sample
// - Direct latencies equal write latency minus two
// - Two-clock preamble: write latency minus three
// - Read disables termination after read latency minus two (three with two-clock preamble)
// - Chopped read: park back after four/five
// - Full read: park back after six/seven
// - Hold counted from pin high or write
// - No termination while driving read data
// - Dynamic switching enabled by mode bits
// - Values from mode register fields
// - Idle: pin times nominal, park when low
// - Write selects write termination after latency
// - Write deselect after four or six
// - Deselect offsets adjusted for CRC, preamble
// - Priority: read, write, nominal, park
// - Read disable lasts half burst plus X
module dotc_odt_ctrl (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  input  wire logic        ce_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        mem_ck_i,
  input  wire logic        odt_i,
  input  wire logic        wr_cmd_i,
  input  wire logic        rd_cmd_i,
  input  wire logic        burst_chop_four_i,
  input  wire logic        dll_locked_i,
  output logic      [4:0]  term_state_o,
  output logic      [2:0]  rtt_code_o,
  output logic             sync_mode_o,
  output logic             odt_hold_err_o
);
  localparam int unsigned CW = dotc_pkg::CNT_W;

  logic [dotc_pkg::PIN_W-1:0]  pin_s1_q, pin_s2_q;
  logic                        ck_prev_q;
  logic [dotc_pkg::MODE_W-1:0] mode_register_1_q, mode_register_2_q, mode_register_5_q;
  logic [31:0]                 lat_q;
  logic [dotc_pkg::CFG_W-1:0]  cfg_q;
  logic [31:0]                 prdata_q;
  dotc_pkg::dotc_term_t        term_q, term_d;
  logic [dotc_pkg::RTT_W-1:0]  rtt_code_q, rtt_code_d;
  logic [CW-1:0]               rd_cnt_q, rd_cnt_d, wr_cnt_q, wr_cnt_d, hold_cnt_q;
  logic                        odt_prev_q, hold_err_q;

  function automatic logic [dotc_pkg::LAT_W-1:0] lat_calc(input logic [7:0] s,
                                                          input logic [7:0] b);
    logic [7:0] d;
    d = s - b;
    if (s <= b) lat_calc = '0;
    else if (d > {2'b00, dotc_pkg::LAT_MAX}) lat_calc = dotc_pkg::LAT_MAX;
    else lat_calc = d[dotc_pkg::LAT_W-1:0];
  endfunction

  // Pin synchronisers
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_s1_q  <= '0;
      pin_s2_q  <= '0;
      ck_prev_q <= 1'b0;
    end else if (ce_i) begin
      pin_s1_q  <= {dll_locked_i, burst_chop_four_i, rd_cmd_i, wr_cmd_i, odt_i, mem_ck_i};
      pin_s2_q  <= pin_s1_q;
      ck_prev_q <= pin_s2_q[dotc_pkg::PIN_CK];
    end
  end

  wire logic ck_rise, odt_s, wr_s, rd_s, chop_s, locked, sync_step;
  assign ck_rise   = pin_s2_q[dotc_pkg::PIN_CK] & ~ck_prev_q;
  assign odt_s     = pin_s2_q[dotc_pkg::PIN_ODT];
  assign wr_s      = pin_s2_q[dotc_pkg::PIN_WR];
  assign rd_s      = pin_s2_q[dotc_pkg::PIN_RD];
  assign chop_s    = pin_s2_q[dotc_pkg::PIN_CHOP];
  assign locked    = pin_s2_q[dotc_pkg::PIN_LOCK];
  assign sync_step = ck_rise & locked;

  // Mode fields
  wire logic [2:0] nom_val, wr_val, park_val;
  wire logic       nom_en, park_en, dyn_en, pre2, crc_en, cfg_chop;
  wire logic [4:0] cwl, al, cl;
  wire logic [3:0] pl;
  assign nom_val  = mode_register_1_q[dotc_pkg::MR1_NOM_LSB +: dotc_pkg::RTT_W];
  assign wr_val   = mode_register_2_q[dotc_pkg::MR2_WR_LSB +: dotc_pkg::RTT_W];
  assign park_val = mode_register_5_q[dotc_pkg::MR5_PARK_LSB +: dotc_pkg::RTT_W];
  assign nom_en   = (nom_val != '0);
  assign park_en  = (park_val != '0);
  // either low write-field bit enables switching
  assign dyn_en   = wr_val[0] | wr_val[1];
  assign pre2     = cfg_q[dotc_pkg::CFG_PRE2_BIT];
  assign crc_en   = cfg_q[dotc_pkg::CFG_CRC_BIT];
  assign cfg_chop = cfg_q[dotc_pkg::CFG_CHOP_BIT];
  assign cwl      = lat_q[dotc_pkg::LAT_CWL_LSB +: 5];
  assign al       = lat_q[dotc_pkg::LAT_AL_LSB +: 5];
  assign pl       = lat_q[dotc_pkg::LAT_PL_LSB +: 4];
  assign cl       = lat_q[dotc_pkg::LAT_CL_LSB +: 5];

  wire logic [7:0] wl_sum, rl_sum, lat_sub;
  wire logic [dotc_pkg::LAT_W-1:0] dlat, rlat;
  assign wl_sum  = {3'h0, cwl} + {3'h0, al} + {4'h0, pl};
  assign rl_sum  = {3'h0, cl} + {3'h0, al} + {4'h0, pl};
  assign lat_sub = pre2 ? dotc_pkg::SUB_PRE2 : dotc_pkg::SUB_PRE1;
  assign dlat    = lat_calc(wl_sum, lat_sub);
  // read latency minus two or three
  assign rlat    = lat_calc(rl_sum, lat_sub);

  // Latency lines
  dotc_tap_if odt_if ();
  dotc_tap_if wr_if ();
  dotc_tap_if rd_if ();
  assign odt_if.step  = sync_step;
  assign odt_if.clear = ~locked;
  assign odt_if.din   = {1'b0, odt_s};
  assign odt_if.lat   = dlat;
  assign wr_if.step   = sync_step;
  assign wr_if.clear  = ~locked;
  assign wr_if.din    = {chop_s, wr_s};
  assign wr_if.lat    = dlat;
  assign rd_if.step   = sync_step;
  assign rd_if.clear  = ~locked;
  assign rd_if.din    = {chop_s, rd_s};
  assign rd_if.lat    = rlat;

  dotc_delay_line u_odt_line (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
                              .tap_if(odt_if));
  dotc_delay_line u_wr_line  (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
                              .tap_if(wr_if));
  dotc_delay_line u_rd_line  (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
                              .tap_if(rd_if));

  // Window lengths
  wire logic          rd_fire, rd_chop, wr_fire, wr_chop, rd_act, wr_act, nom_act;
  wire logic [CW-1:0] rd_len, wr_len_c, wr_len_f, wr_len;
  assign rd_fire = rd_if.tap[0];
  assign rd_chop = rd_if.tap[1];
  assign wr_fire = wr_if.tap[0] & dyn_en;
  assign wr_chop = wr_if.tap[1];
  assign rd_len  = rd_chop ? (pre2 ? dotc_pkg::RD_BC4_PRE2 : dotc_pkg::RD_BC4_PRE1)
                           : (pre2 ? dotc_pkg::RD_BL8_PRE2 : dotc_pkg::RD_BL8_PRE1);
  assign wr_len_c = pre2 ? (crc_en ? dotc_pkg::WR_BC4_P2_C1 : dotc_pkg::WR_BC4_P2_C0)
                         : (crc_en ? dotc_pkg::WR_BC4_P1_C1 : dotc_pkg::WR_BC4_P1_C0);
  assign wr_len_f = pre2 ? (crc_en ? dotc_pkg::WR_BL8_P2_C1 : dotc_pkg::WR_BL8_P2_C0)
                         : (crc_en ? dotc_pkg::WR_BL8_P1_C1 : dotc_pkg::WR_BL8_P1_C0);
  assign wr_len   = wr_chop ? wr_len_c : wr_len_f;
  assign rd_act   = rd_fire | (rd_cnt_q != '0);
  assign wr_act   = wr_fire | (wr_cnt_q != '0);
  assign nom_act  = odt_if.tap[0] & nom_en;

  always_comb begin
    rd_cnt_d = rd_fire ? rd_len - 4'h1 : ((rd_cnt_q != '0) ? rd_cnt_q - 4'h1 : '0);
    wr_cnt_d = wr_fire ? wr_len - 4'h1 : ((wr_cnt_q != '0) ? wr_cnt_q - 4'h1 : '0);
    // read over write over nominal over park
    if (!locked) term_d = (odt_s & nom_en) ? dotc_pkg::TERM_NOM
                          : (park_en ? dotc_pkg::TERM_PARK : dotc_pkg::TERM_HIZ);
    else if (rd_act) term_d = dotc_pkg::TERM_DIS;
    else if (wr_act) term_d = dotc_pkg::TERM_WR;
    else if (nom_act) term_d = dotc_pkg::TERM_NOM;
    else if (park_en) term_d = dotc_pkg::TERM_PARK;
    else term_d = dotc_pkg::TERM_HIZ;
    case (term_d)
      dotc_pkg::TERM_NOM:  rtt_code_d = nom_val;
      dotc_pkg::TERM_WR:   rtt_code_d = wr_val;
      dotc_pkg::TERM_PARK: rtt_code_d = park_val;
      default:             rtt_code_d = '0;
    endcase
  end

  wire logic term_upd;
  assign term_upd = sync_step | ~locked;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      term_q     <= dotc_pkg::TERM_HIZ;
      rtt_code_q <= '0;
      rd_cnt_q   <= '0;
      wr_cnt_q   <= '0;
    end else if (ce_i && term_upd) begin
      term_q     <= term_d;
      rtt_code_q <= rtt_code_d;
      rd_cnt_q   <= locked ? rd_cnt_d : '0;
      wr_cnt_q   <= locked ? wr_cnt_d : '0;
    end
  end

  // Minimum assertion time check
  wire logic [CW-1:0] hold_base, hold_need;
  wire logic          hold_start, hold_set, hold_clr, acc, wr_en, rd_setup;
  assign hold_base  = cfg_chop ? (pre2 ? dotc_pkg::HOLD_BC4_PRE2 : dotc_pkg::HOLD_BC4_PRE1)
                               : (pre2 ? dotc_pkg::HOLD_BL8_PRE2 : dotc_pkg::HOLD_BL8_PRE1);
  assign hold_need  = crc_en ? hold_base + dotc_pkg::HOLD_CRC_EXT : hold_base;
  // count from first high or write
  assign hold_start = odt_s & (~odt_prev_q | wr_s);
  // flag a pin dropped too early
  assign hold_set   = sync_step & ~odt_s & odt_prev_q & (hold_cnt_q < hold_need);
  assign acc        = psel_i & penable_i;
  assign wr_en      = acc & pwrite_i;
  assign rd_setup   = psel_i & ~penable_i & ~pwrite_i;
  assign hold_clr   = wr_en & (paddr_i == dotc_pkg::ADDR_STAT) &
                      pwdata_i[dotc_pkg::STAT_HERR_BIT];

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      odt_prev_q <= 1'b0;
      hold_cnt_q <= '0;
    end else if (ce_i && sync_step) begin
      odt_prev_q <= odt_s;
      if (hold_start) hold_cnt_q <= 4'h1;
      else if (odt_s && hold_cnt_q < hold_need) hold_cnt_q <= hold_cnt_q + 4'h1;
    end
  end

  // Set wins over clear
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) hold_err_q <= 1'b0;
    else if (ce_i) hold_err_q <= hold_set | (hold_err_q & ~hold_clr);
  end

  // APB register file
  wire logic hit_m1, hit_m2, hit_m5, hit_lat, hit_cfg, hit_stat, mapped;
  wire logic [31:0] stat_word, rd_mux;
  assign hit_m1    = (paddr_i == dotc_pkg::ADDR_MODE1);
  assign hit_m2    = (paddr_i == dotc_pkg::ADDR_MODE2);
  assign hit_m5    = (paddr_i == dotc_pkg::ADDR_MODE5);
  assign hit_lat   = (paddr_i == dotc_pkg::ADDR_LAT);
  assign hit_cfg   = (paddr_i == dotc_pkg::ADDR_CFG);
  assign hit_stat  = (paddr_i == dotc_pkg::ADDR_STAT);
  assign mapped    = hit_m1 | hit_m2 | hit_m5 | hit_lat | hit_cfg | hit_stat;
  assign stat_word = (32'(term_q) << dotc_pkg::STAT_TERM_LSB) |
                     (32'(locked) << dotc_pkg::STAT_LOCK_BIT) |
                     (32'(hold_err_q) << dotc_pkg::STAT_HERR_BIT) |
                     (32'(rtt_code_q) << dotc_pkg::STAT_CODE_LSB);
  assign rd_mux    = hit_m1  ? 32'(mode_register_1_q) :
                     hit_m2  ? 32'(mode_register_2_q) :
                     hit_m5  ? 32'(mode_register_5_q) :
                     hit_lat ? lat_q :
                     hit_cfg ? 32'(cfg_q) :
                     hit_stat ? stat_word : 32'h0000_0000;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_register_1_q <= dotc_pkg::MODE_RST;
      mode_register_2_q <= dotc_pkg::MODE_RST;
      mode_register_5_q <= dotc_pkg::MODE_RST;
      lat_q             <= dotc_pkg::LAT_RST;
      cfg_q             <= dotc_pkg::CFG_RST;
      prdata_q          <= 32'h0000_0000;
    end else if (ce_i) begin
      if (wr_en && hit_m1) mode_register_1_q <= pwdata_i[dotc_pkg::MODE_W-1:0];
      if (wr_en && hit_m2) mode_register_2_q <= pwdata_i[dotc_pkg::MODE_W-1:0];
      if (wr_en && hit_m5) mode_register_5_q <= pwdata_i[dotc_pkg::MODE_W-1:0];
      if (wr_en && hit_lat) lat_q <= pwdata_i;
      if (wr_en && hit_cfg) cfg_q <= pwdata_i[dotc_pkg::CFG_W-1:0];
      if (rd_setup) prdata_q <= rd_mux;
    end
  end

  assign prdata_o       = prdata_q;
  assign pready_o       = 1'b1;
  assign pslverr_o      = acc & ~mapped;
  assign term_state_o   = term_q;
  assign rtt_code_o     = rtt_code_q;
  assign sync_mode_o    = locked;
  assign odt_hold_err_o = hold_err_q;

  default clocking dc @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  rd_disable_a: assert property (ce_i && sync_step && rd_fire |=> term_q == dotc_pkg::TERM_DIS)
    else $error("read did not disable termination");
  wr_over_nom_a: assert property (ce_i && sync_step && !rd_act && wr_fire && nom_act
                                  |=> term_q == dotc_pkg::TERM_WR)
    else $error("write termination lost priority");
  park_low_a: assert property (ce_i && sync_step && !rd_act && !wr_act && !odt_if.tap[0]
                               && park_en |=> term_q == dotc_pkg::TERM_PARK)
    else $error("park not applied with pin low");
  rd_full_len_a: assert property (ce_i && sync_step && rd_fire && !rd_chop && !pre2
                                  |=> rd_cnt_q == 4'h5)
    else $error("full read window length wrong");
  rd_chop_len_a: assert property (ce_i && sync_step && rd_fire && rd_chop && pre2
                                  |=> rd_cnt_q == 4'h4)
    else $error("chopped read window length wrong");
  dyn_off_a: assert property (!dyn_en && $stable(mode_register_2_q) && term_q !=
                              dotc_pkg::TERM_WR |=> term_q != dotc_pkg::TERM_WR)
    else $error("write termination without dynamic mode");
  direct_lat_a: assert property (!pre2 && wl_sum > 8'h02 && wl_sum < 8'h40
                                 |-> odt_if.lat == 6'(wl_sum - 8'h02))
    else $error("direct latency not write latency minus two");
  code_nom_a: assert property (term_q == dotc_pkg::TERM_NOM && $stable(mode_register_1_q)
                               |-> rtt_code_q == nom_val)
    else $error("nominal code not from mode field");
  wr_crc_len_a: assert property (ce_i && sync_step && !rd_act && wr_fire && !wr_chop &&
                                 crc_en && !pre2 |=> wr_cnt_q == 4'h6)
    else $error("write window length wrong with CRC");
endmodule

// ==== testbench/dotc_host_model.sv ====
// Memory controller model: memory clock, termination pin and commands
module dotc_host_model (
  input  wire logic clk_sys_i,
  output logic      mem_ck_o,
  output logic      odt_o,
  output logic      wr_cmd_o,
  output logic      rd_cmd_o,
  output logic      chop_o,
  output int        step_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    mem_ck_o = 1'b0;
    odt_o    = 1'b0;
    wr_cmd_o = 1'b0;
    rd_cmd_o = 1'b0;
    chop_o   = 1'b0;
    #3.3;
    forever #62.5 mem_ck_o = ~mem_ck_o;
  end

  always @(posedge mem_ck_o) step_o <= step_o + 1;

  // Pins change mid-period; a command covers one rise, then chop is inverted
  task automatic send(input logic odt, input logic wr, input logic rd, input logic chop,
                      output int s);
    @(negedge mem_ck_o);
    @(posedge clk_sys_i);
    odt_o    <= odt;
    wr_cmd_o <= wr;
    rd_cmd_o <= rd;
    chop_o   <= chop;
    s = step_o + 1;
    @(negedge mem_ck_o);
    @(posedge clk_sys_i);
    wr_cmd_o <= 1'b0;
    rd_cmd_o <= 1'b0;
    chop_o   <= ~chop;
  endtask
endmodule

// ==== testbench/dotc_odt_ctrl_tb.sv ====
// Self-checking bench for the termination timing control block
module dotc_odt_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, rerr;
  logic        mem_ck, odt, wr, rd, chop, dll, sync_mode, herr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [4:0]  term;
  logic [2:0]  rtt;
  int          step, fails, n_tests, cyc;

  dotc_odt_ctrl dut (.clk_sys_i(clk), .rst_b_i(rst_b), .ce_i(1'b1), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .mem_ck_i(mem_ck),
    .odt_i(odt), .wr_cmd_i(wr), .rd_cmd_i(rd), .burst_chop_four_i(chop),
    .dll_locked_i(dll), .term_state_o(term), .rtt_code_o(rtt), .sync_mode_o(sync_mode),
    .odt_hold_err_o(herr));
  dotc_host_model host (.clk_sys_i(clk), .mem_ck_o(mem_ck), .odt_o(odt), .wr_cmd_o(wr),
    .rd_cmd_o(rd), .chop_o(chop), .step_o(step));

  always #5 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Waits to the middle of memory step s, then checks state and code
  task automatic at(input int s, input dotc_pkg::dotc_term_t st, input logic [2:0] code,
                    input string name);
    while (step < s) @(negedge mem_ck);
    n_tests++;
    if (term !== 5'(st) || rtt !== code) begin
      fails++;
      $display("BAD %s expected %h/%h seen %h/%h", name, st, code, term, rtt);
    end
  endtask

  task automatic apb(input logic is_wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= is_wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic t_regs();
    at(1, dotc_pkg::TERM_HIZ, 3'h0, "reset state");
    apb(1'b0, dotc_pkg::ADDR_STAT, 32'h0);
    chk_word("reset status", 32'h0000_0001, rdat);
    apb(1'b1, dotc_pkg::ADDR_MODE1, 32'h0000_0500);
    apb(1'b1, dotc_pkg::ADDR_MODE2, 32'h0000_0600);
    apb(1'b1, dotc_pkg::ADDR_MODE5, 32'h0000_0080);
    apb(1'b1, dotc_pkg::ADDR_LAT, 32'h0702_0205);
    apb(1'b0, dotc_pkg::ADDR_LAT, 32'h0);
    chk_word("latency readback", 32'h0702_0205, rdat);
    apb(1'b0, 12'h018, 32'h0);
    chk_word("unmapped data", 32'h0, rdat);
    chk_word("unmapped error", 32'h1, {31'h0, rerr});
    dll <= 1'b1;
    for (int i = 0; i < 20 && sync_mode !== 1'b1; i++) @(posedge clk);
    chk_word("sync mode", 32'h1, {31'h0, sync_mode});
    at(step + 2, dotc_pkg::TERM_PARK, 3'h2, "idle park");
  endtask

  task automatic t_direct();
    int s;
    int k;
    int lat;
    for (int pre = 0; pre < 2; pre++) begin
      lat = 7 - pre;
      apb(1'b1, dotc_pkg::ADDR_CFG, 32'(pre));
      host.send(1'b1, 1'b0, 1'b0, 1'b0, s);
      at(s + lat - 1, dotc_pkg::TERM_PARK, 3'h2, "nominal early");
      at(s + lat, dotc_pkg::TERM_NOM, 3'h5, "nominal on");
      // Pin held past the minimum assertion time
      at(s + lat + 2, dotc_pkg::TERM_NOM, 3'h5, "nominal held");
      host.send(1'b0, 1'b0, 1'b0, 1'b0, k);
      at(k + lat - 1, dotc_pkg::TERM_NOM, 3'h5, "nominal late");
      at(k + lat, dotc_pkg::TERM_PARK, 3'h2, "nominal off");
    end
  endtask

  task automatic t_read();
    int s;
    int lat;
    int w;
    int rd_w [4] = '{6, 7, 4, 5};
    for (int i = 0; i < 4; i++) begin
      lat = 9 - i % 2;
      w = rd_w[i];
      apb(1'b1, dotc_pkg::ADDR_CFG, 32'(i % 2));
      host.send(1'b0, 1'b0, 1'b1, 1'(i / 2), s);
      at(s + lat - 1, dotc_pkg::TERM_PARK, 3'h2, "read early");
      at(s + lat, dotc_pkg::TERM_DIS, 3'h0, "read off");
      at(s + lat + w - 1, dotc_pkg::TERM_DIS, 3'h0, "read last");
      at(s + lat + w, dotc_pkg::TERM_PARK, 3'h2, "read park");
    end
  endtask

  task automatic t_write();
    int s;
    int lat;
    int w;
    int wr_w [8] = '{6, 7, 7, 8, 4, 7, 5, 8};
    for (int i = 0; i < 8; i++) begin
      lat = 7 - (i / 2) % 2;
      w = wr_w[i];
      apb(1'b1, dotc_pkg::ADDR_CFG, 32'((i / 2) % 2 + (i % 2) * 2));
      host.send(1'b0, 1'b1, 1'b0, 1'(i / 4), s);
      at(s + lat - 1, dotc_pkg::TERM_PARK, 3'h2, "write early");
      at(s + lat, dotc_pkg::TERM_WR, 3'h3, "write on");
      at(s + lat + w - 1, dotc_pkg::TERM_WR, 3'h3, "write last");
      at(s + lat + w, dotc_pkg::TERM_PARK, 3'h2, "write off");
    end
  endtask

  task automatic t_prio();
    int s;
    int r;
    apb(1'b1, dotc_pkg::ADDR_CFG, 32'h0);
    host.send(1'b1, 1'b0, 1'b0, 1'b0, s);
    host.send(1'b1, 1'b1, 1'b0, 1'b0, s);
    at(s + 7, dotc_pkg::TERM_WR, 3'h3, "write over nominal");
    at(s + 13, dotc_pkg::TERM_NOM, 3'h5, "nominal after write");
    host.send(1'b1, 1'b0, 1'b1, 1'b0, r);
    at(r + 9, dotc_pkg::TERM_DIS, 3'h0, "read over nominal");
    at(r + 15, dotc_pkg::TERM_NOM, 3'h5, "nominal after read");
    host.send(1'b0, 1'b0, 1'b0, 1'b0, r);
    at(r + 7, dotc_pkg::TERM_PARK, 3'h2, "park after drop");
  endtask

  task automatic t_hold();
    int s;
    apb(1'b1, dotc_pkg::ADDR_CFG, 32'h4);
    host.send(1'b1, 1'b0, 1'b0, 1'b0, s);
    at(s + 2, dotc_pkg::TERM_PARK, 3'h2, "hold park");
    host.send(1'b0, 1'b0, 1'b0, 1'b0, s);
    apb(1'b0, dotc_pkg::ADDR_STAT, 32'h0);
    chk_word("hold exact", 32'h0, rdat & 32'h200);
    host.send(1'b1, 1'b0, 1'b0, 1'b0, s);
    host.send(1'b0, 1'b0, 1'b0, 1'b0, s);
    at(s + 5, dotc_pkg::TERM_NOM, 3'h5, "short pulse");
    at(s + 7, dotc_pkg::TERM_PARK, 3'h2, "short pulse off");
    apb(1'b0, dotc_pkg::ADDR_STAT, 32'h0);
    chk_word("hold short", 32'h200, rdat & 32'h200);
    chk_word("hold flag", 32'h1, {31'h0, herr});
    apb(1'b1, dotc_pkg::ADDR_STAT, 32'h200);
    apb(1'b0, dotc_pkg::ADDR_STAT, 32'h0);
    chk_word("hold cleared", 32'h0, rdat & 32'h200);
    chk_word("hold flag clear", 32'h0, {31'h0, herr});
  endtask

  task automatic t_dyn_off();
    int s;
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, dotc_pkg::ADDR_MODE2, i == 1 ? 32'h400 : 32'h0);
      host.send(1'b0, 1'b1, 1'b0, 1'b0, s);
      at(s + 7, i == 1 ? dotc_pkg::TERM_WR : dotc_pkg::TERM_PARK, 3'h2, "dynamic");
    end
    apb(1'b1, dotc_pkg::ADDR_MODE2, 32'h0);
    dll <= 1'b0;
    for (int i = 0; i < 20 && sync_mode !== 1'b0; i++) @(posedge clk);
    chk_word("async mode", 32'h0, {31'h0, sync_mode});
  endtask

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    dll = 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_direct();
    t_read();
    t_write();
    t_prio();
    t_hold();
    t_dyn_off();
    stop_test();
  end
endmodule
